// ===== design/digital_io_point.sv
// What this block does
// - direction selects contact input, voltage input or driven output
// - contact mode: result on while contact closed, else off
// - voltage mode: result on while adequate voltage seen, else off
// - output mode takes a digital on/off or an analog percent command
// - off or 0% scaled duty holds output off; on or 100% scaled duty holds it on
// - between limits, average on-time equals the percent via chosen method
// - fixed method: on for percent times period, off for the rest, repeating
// - fixed period programmable 0.1 to 60.0 s, used only by fixed method
// - variable method switches on whole line cycles, at most every three
// - low scale 0.0 to 100.0% gives power at 0% command
// - high scale 0.0 to 100.0% gives power at 100% command
// - commands map linearly between low and high scale before modulation
// - variable method is meant only for solid-state or thyristor loads
//
// The placing of the registers and the address-and-strobe port were decided locally.
`default_nettype none
module digital_io_point
    import dio_pkg::*;
#(
    parameter int CYCLES_PER_MS = MS_CYCLES
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    // field side
    input  wire logic              contactClosed,
    input  wire logic              voltageOk,
    input  wire logic              lineCycle,
    output logic                   driveOut,
    output logic                   driveEn_n,
    // application side
    output logic                   digitalResult
);
    // configuration
    logic [1:0]       dir;
    logic             varBase;
    logic             analogCmd;
    logic [PCT_W-1:0] periodTenths;
    logic [PCT_W-1:0] lowScale;
    logic [PCT_W-1:0] highScale;
    logic [PCT_W-1:0] cmdPct;
    logic             cmdOn;
    logic [PCT_W-1:0] effDuty;
    logic [1:0]       next_dir;
    logic             next_varBase;
    logic             next_analogCmd;
    logic [PCT_W-1:0] next_periodTenths;
    logic [PCT_W-1:0] next_lowScale;
    logic [PCT_W-1:0] next_highScale;
    logic [PCT_W-1:0] next_cmdPct;
    logic             next_cmdOn;
    logic [PCT_W-1:0] next_effDuty;
    logic [DATA_W-1:0] next_rdata;
    // fixed time base
    fix_state_t       fixState;
    fix_state_t       next_fixState;
    logic [16:0]      tickCnt;
    logic [16:0]      next_tickCnt;
    logic             msTick;
    logic [15:0]      periodCnt;
    logic [15:0]      holdOn;
    logic [15:0]      holdLen;
    logic [15:0]      next_periodCnt;
    logic [15:0]      next_holdOn;
    logic [15:0]      next_holdLen;
    logic [15:0]      calcOn;
    logic [15:0]      calcLen;
    logic             fixedActive;
    logic             periodEnd;
    // outputs
    logic             varLevel;
    logic             next_driveOut;
    logic             next_driveEn_n;
    logic             next_digitalResult;

    function automatic logic [PCT_W-1:0] clampPct(input logic [DATA_W-1:0] v);
        clampPct = (v > {22'h0, PCT_FULL}) ? PCT_FULL : v[PCT_W-1:0];
    endfunction

    function automatic logic [PCT_W-1:0] scalePct(input logic [PCT_W-1:0] lo,
                                                  input logic [PCT_W-1:0] hi,
                                                  input logic [PCT_W-1:0] c);
        logic [31:0] acc;
        acc = 32'(lo) * 32'(PCT_FULL - c) + 32'(hi) * 32'(c);
        scalePct = PCT_W'(acc / 32'(PCT_SCALE));
    endfunction

    // register writes and reads
    always_comb begin
        next_dir          = dir;
        next_varBase      = varBase;
        next_analogCmd    = analogCmd;
        next_periodTenths = periodTenths;
        next_lowScale     = lowScale;
        next_highScale    = highScale;
        next_cmdPct       = cmdPct;
        next_cmdOn        = cmdOn;
        next_rdata        = '0;
        if (wr) begin
            case (addr)
                OFF_CTRL: begin
                    if (wdata[CTRL_DIR_LSB+1:CTRL_DIR_LSB] != 2'b11) begin
                        next_dir = wdata[CTRL_DIR_LSB+1:CTRL_DIR_LSB];
                    end
                    next_varBase   = wdata[CTRL_TB_BIT];
                    next_analogCmd = wdata[CTRL_ANALOG_BIT];
                end
                OFF_PERIOD: begin
                    if (wdata < {22'h0, PERIOD_MIN}) begin
                        next_periodTenths = PERIOD_MIN;
                    end else if (wdata > {22'h0, PERIOD_MAX}) begin
                        next_periodTenths = PERIOD_MAX;
                    end else begin
                        next_periodTenths = wdata[PCT_W-1:0];
                    end
                end
                OFF_LOW:  next_lowScale  = clampPct(wdata);
                OFF_HIGH: next_highScale = clampPct(wdata);
                OFF_CMD: begin
                    next_cmdPct = clampPct({16'h0, wdata[15:0]});
                    next_cmdOn  = wdata[CMD_ON_BIT];
                end
                default: ;
            endcase
        end
        if (rd) begin
            case (addr)
                OFF_CTRL: begin
                    next_rdata[CTRL_DIR_LSB+1:CTRL_DIR_LSB] = dir;
                    next_rdata[CTRL_TB_BIT]                 = varBase;
                    next_rdata[CTRL_ANALOG_BIT]             = analogCmd;
                end
                OFF_PERIOD: next_rdata[PCT_W-1:0] = periodTenths;
                OFF_LOW:    next_rdata[PCT_W-1:0] = lowScale;
                OFF_HIGH:   next_rdata[PCT_W-1:0] = highScale;
                OFF_CMD: begin
                    next_rdata[PCT_W-1:0]  = cmdPct;
                    next_rdata[CMD_ON_BIT] = cmdOn;
                end
                OFF_STATUS: begin
                    next_rdata[STAT_RESULT_BIT] = digitalResult;
                    next_rdata[STAT_DRIVE_BIT]  = driveOut;
                    next_rdata[STAT_FIXON_BIT]  = (fixState == FX_ON);
                    next_rdata[STAT_VARON_BIT]  = varLevel;
                    next_rdata[STAT_EFF_LSB+PCT_W-1:STAT_EFF_LSB] = effDuty;
                end
                default: next_rdata = '0;
            endcase
        end
        next_effDuty = scalePct(lowScale, highScale, cmdPct);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dir          <= DIR_CONTACT;
            varBase      <= 1'b0;
            analogCmd    <= 1'b0;
            periodTenths <= PERIOD_RST;
            lowScale     <= PCT_ZERO;
            highScale    <= PCT_FULL;
            cmdPct       <= PCT_ZERO;
            cmdOn        <= 1'b0;
            effDuty      <= PCT_ZERO;
            rdata        <= '0;
        end else begin
            dir          <= next_dir;
            varBase      <= next_varBase;
            analogCmd    <= next_analogCmd;
            periodTenths <= next_periodTenths;
            lowScale     <= next_lowScale;
            highScale    <= next_highScale;
            cmdPct       <= next_cmdPct;
            cmdOn        <= next_cmdOn;
            effDuty      <= next_effDuty;
            rdata        <= next_rdata;
        end
    end

    // fixed time base: millisecond tick and period sequencer
    assign fixedActive = (dir == DIR_OUTPUT) && analogCmd && !varBase;
    assign msTick      = (tickCnt == 17'(CYCLES_PER_MS - 1));
    assign calcLen     = 16'(32'(periodTenths) * 32'(MS_PER_TENTH));
    assign calcOn      = 16'((32'(effDuty) * 32'(periodTenths)) / 32'(TENTHS_PER_UNIT));
    assign periodEnd   = msTick && (periodCnt + 16'h1 >= holdLen);

    always_comb begin
        next_tickCnt   = msTick ? 17'h0 : tickCnt + 17'h1;
        next_fixState  = fixState;
        next_periodCnt = periodCnt;
        next_holdOn    = holdOn;
        next_holdLen   = holdLen;
        case (fixState)
            FX_IDLE: begin
                next_periodCnt = 16'h0;
                if (fixedActive) begin
                    next_holdOn   = calcOn;
                    next_holdLen  = calcLen;
                    next_fixState = (calcOn != 16'h0) ? FX_ON : FX_OFF;
                end
            end
            FX_ON, FX_OFF: begin
                if (periodEnd) begin
                    next_periodCnt = 16'h0;
                    next_holdOn    = calcOn;
                    next_holdLen   = calcLen;
                    next_fixState  = (calcOn != 16'h0) ? FX_ON : FX_OFF;
                end else if (msTick) begin
                    next_periodCnt = periodCnt + 16'h1;
                    if (periodCnt + 16'h1 >= holdOn) begin
                        next_fixState = FX_OFF;
                    end
                end
            end
            default: next_fixState = FX_IDLE;
        endcase
        if (!fixedActive) begin
            next_fixState  = FX_IDLE;
            next_periodCnt = 16'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tickCnt   <= 17'h0;
            fixState  <= FX_IDLE;
            periodCnt <= 16'h0;
            holdOn    <= 16'h0;
            holdLen   <= 16'h0;
        end else begin
            tickCnt   <= next_tickCnt;
            fixState  <= next_fixState;
            periodCnt <= next_periodCnt;
            holdOn    <= next_holdOn;
            holdLen   <= next_holdLen;
        end
    end

    // variable time base
    line_cycle_modulator u_lineMod (
        .clk      (clk),
        .rst      (rst),
        .enable   ((dir == DIR_OUTPUT) && analogCmd && varBase),
        .lineTick (lineCycle),
        .duty     (effDuty),
        .level    (varLevel)
    );

    // pin and result selection
    always_comb begin
        next_driveEn_n     = (dir != DIR_OUTPUT);
        next_digitalResult = 1'b0;
        next_driveOut      = 1'b0;
        case (dir)
            DIR_CONTACT: next_digitalResult = contactClosed;
            DIR_VOLTAGE: next_digitalResult = voltageOk;
            DIR_OUTPUT: begin
                if (!analogCmd) begin
                    next_driveOut = cmdOn;
                end else if (effDuty == PCT_ZERO) begin
                    next_driveOut = 1'b0;
                end else if (effDuty >= PCT_FULL) begin
                    next_driveOut = 1'b1;
                end else begin
                    next_driveOut = varBase ? varLevel : (fixState == FX_ON);
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            driveOut      <= 1'b0;
            driveEn_n     <= 1'b1;
            digitalResult <= 1'b0;
        end else begin
            driveOut      <= next_driveOut;
            driveEn_n     <= next_driveEn_n;
            digitalResult <= next_digitalResult;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    dir_enable_a: assert property ((dir == DIR_OUTPUT) |=> !driveEn_n)
        else $error("output mode did not enable the driver");
    contact_follow_a: assert property ((dir == DIR_CONTACT)
        |=> digitalResult == $past(contactClosed) && driveEn_n)
        else $error("contact result does not follow the contact");
    voltage_follow_a: assert property ((dir == DIR_VOLTAGE)
        |=> digitalResult == $past(voltageOk))
        else $error("voltage result does not follow the input");
    digital_cmd_a: assert property ((dir == DIR_OUTPUT && !analogCmd)
        |=> driveOut == $past(cmdOn))
        else $error("digital command not driven");
    zero_off_a: assert property ((dir == DIR_OUTPUT && analogCmd && effDuty == PCT_ZERO)
        |=> !driveOut)
        else $error("zero duty did not hold output off");
    full_on_a: assert property ((dir == DIR_OUTPUT && analogCmd && effDuty == PCT_FULL)
        |=> driveOut)
        else $error("full duty did not hold output on");
    fixed_drive_a: assert property ((fixedActive && effDuty != PCT_ZERO
        && effDuty != PCT_FULL) |=> driveOut == $past(fixState == FX_ON))
        else $error("fixed drive does not follow the sequencer");
    on_portion_a: assert property ((fixState == FX_ON && fixedActive)
        |-> periodCnt < holdOn)
        else $error("on phase ran past its portion");
    period_range_a: assert property ((periodTenths >= PERIOD_MIN
        && periodTenths <= PERIOD_MAX))
        else $error("period out of range");
    low_scale_a: assert property (($past(cmdPct) == PCT_ZERO)
        |-> effDuty == $past(lowScale))
        else $error("zero command did not give low scale");
    high_scale_a: assert property (($past(cmdPct) == PCT_FULL)
        |-> effDuty == $past(highScale))
        else $error("full command did not give high scale");
    scale_bound_a: assert property (($past(lowScale) <= $past(highScale))
        |-> effDuty >= $past(lowScale) && effDuty <= $past(highScale))
        else $error("scaled duty outside scale span");
    duty_hold_a: assert property ((fixState != FX_IDLE && fixedActive && !periodEnd)
        |=> $stable(holdOn) && $stable(holdLen))
        else $error("duty changed inside a period");
endmodule
`default_nettype wire

// ===== design/dio_pkg.sv
`default_nettype none
package dio_pkg;
    // register bus
    localparam int            ADDR_W     = 8;
    localparam int            DATA_W     = 32;
    localparam logic [7:0]    OFF_CTRL   = 8'h00;
    localparam logic [7:0]    OFF_PERIOD = 8'h04;
    localparam logic [7:0]    OFF_LOW    = 8'h08;
    localparam logic [7:0]    OFF_HIGH   = 8'h0C;
    localparam logic [7:0]    OFF_CMD    = 8'h10;
    localparam logic [7:0]    OFF_STATUS = 8'h14;
    // control, command and status fields
    localparam int            CTRL_DIR_LSB    = 0;
    localparam int            CTRL_TB_BIT     = 2;
    localparam int            CTRL_ANALOG_BIT = 3;
    localparam int            CMD_ON_BIT      = 16;
    localparam int            STAT_RESULT_BIT = 0;
    localparam int            STAT_DRIVE_BIT  = 1;
    localparam int            STAT_FIXON_BIT  = 2;
    localparam int            STAT_VARON_BIT  = 3;
    localparam int            STAT_EFF_LSB    = 16;
    // percent in tenths of a percent
    localparam int            PCT_W      = 10;
    localparam logic [9:0]    PCT_ZERO   = 10'h000;
    localparam logic [9:0]    PCT_FULL   = 10'h3E8;
    // fixed time base, in tenths of a second
    localparam logic [9:0]    PERIOD_MIN = 10'h001;
    localparam logic [9:0]    PERIOD_MAX = 10'h258;
    localparam logic [9:0]    PERIOD_RST = 10'h00A;
    localparam int            MS_PER_TENTH = 100;
    localparam int            TENTHS_PER_UNIT = 10;
    localparam int            PCT_SCALE  = 1000;
    // timing
    localparam int            CLK_PERIOD_NS = 8;
    localparam int            TICK_NS       = 1000000;
    localparam int            MS_CYCLES     = TICK_NS / CLK_PERIOD_NS;
    // variable time base: index of the last line cycle in a three-cycle block
    localparam logic [1:0]    BLOCK_LAST = 2'h2;
    typedef enum logic [1:0] {
        DIR_CONTACT = 2'b00,
        DIR_OUTPUT  = 2'b01,
        DIR_VOLTAGE = 2'b10
    } dir_t;
    typedef enum logic [1:0] {
        FX_IDLE = 2'b00,
        FX_ON   = 2'b01,
        FX_OFF  = 2'b10
    } fix_state_t;
endpackage
`default_nettype wire

// ===== design/line_cycle_modulator.sv
`default_nettype none
module line_cycle_modulator
    import dio_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // control
    input  wire logic             enable,
    input  wire logic             lineTick,
    input  wire logic [PCT_W-1:0] duty,
    // result
    output logic                  level
);
    logic [1:0]       cycInBlock;
    logic [PCT_W:0]   acc;
    logic [1:0]       next_cycInBlock;
    logic [PCT_W:0]   next_acc;
    logic             next_level;
    logic [PCT_W+1:0] sum;

    // decide on or off once per block of three line cycles
    always_comb begin
        next_cycInBlock = cycInBlock;
        next_acc        = acc;
        next_level      = level;
        sum             = {1'b0, acc} + {2'b00, duty};
        if (!enable) begin
            next_cycInBlock = 2'h0;
            next_acc        = '0;
            next_level      = 1'b0;
        end else if (lineTick) begin
            next_cycInBlock = (cycInBlock == BLOCK_LAST) ? 2'h0 : cycInBlock + 2'h1;
            if (cycInBlock == 2'h0) begin
                if (sum >= {2'b00, PCT_FULL}) begin
                    next_level = 1'b1;
                    next_acc   = PCT_W'(sum - {2'b00, PCT_FULL}) & {1'b0, {PCT_W{1'b1}}};
                end else begin
                    next_level = 1'b0;
                    next_acc   = sum[PCT_W:0];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cycInBlock <= 2'h0;
            acc        <= '0;
            level      <= 1'b0;
        end else begin
            cycInBlock <= next_cycInBlock;
            acc        <= next_acc;
            level      <= next_level;
        end
    end

    block_edge_a: assert property (@(posedge clk) disable iff (rst)
        (enable && $past(enable) && level != $past(level))
        |-> $past(lineTick) && $past(cycInBlock) == 2'h0)
        else $error("line level changed away from a block start");
endmodule
`default_nettype wire

// ===== test/field_device.sv
`default_nettype none
module field_device #(
    parameter int LINE_CLKS = 20
) (
    // clock
    input  wire logic clk,
    // bench requests
    input  wire logic closeReq,
    input  wire logic voltReq,
    // point side
    input  wire logic driveOut,
    input  wire logic driveEn_n,
    output logic      contactClosed,
    output logic      voltageOk,
    output logic      lineCycle,
    output logic      loadOn
);
    timeunit 1ns;
    timeprecision 1ps;

    int lineCnt = 0;

    // the ac line runs free, one pulse per line cycle
    always @(posedge clk) begin
        lineCnt <= (lineCnt == LINE_CLKS - 1) ? 0 : lineCnt + 1;
    end
    assign lineCycle     = (lineCnt == LINE_CLKS - 1);
    // contact and voltage follow the bench, changed just after an edge
    assign contactClosed = closeReq;
    assign voltageOk     = voltReq;
    // load only sees power while the point drives it
    assign loadOn        = driveOut & ~driveEn_n;
endmodule
`default_nettype wire

// ===== test/testbench.sv
`default_nettype none
module testbench
    import dio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int CPM  = 10;
    localparam int LINE = 20;

    logic              clk;
    logic              rst      = 1'b1;
    logic [ADDR_W-1:0] addr     = 8'h00;
    logic [DATA_W-1:0] wdata    = 32'h0;
    logic              wr       = 1'b0;
    logic              rd       = 1'b0;
    logic              closeReq = 1'b0;
    logic              voltReq  = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic              contactClosed;
    logic              voltageOk;
    logic              lineCycle;
    logic              driveOut;
    logic              driveEn_n;
    logic              digitalResult;
    logic              loadOn;
    int                bad_count  = 0;
    int                num_checks = 0;

    digital_io_point #(.CYCLES_PER_MS(CPM)) u_digital_io_point (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .contactClosed(contactClosed), .voltageOk(voltageOk),
        .lineCycle(lineCycle), .driveOut(driveOut), .driveEn_n(driveEn_n),
        .digitalResult(digitalResult)
    );

    field_device #(.LINE_CLKS(LINE)) u_field_device (
        .clk(clk), .closeReq(closeReq), .voltReq(voltReq), .driveOut(driveOut),
        .driveEn_n(driveEn_n), .contactClosed(contactClosed), .voltageOk(voltageOk),
        .lineCycle(lineCycle), .loadOn(loadOn)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic results();
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic regRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic regCheck(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        regRead(a, d);
        checkVal(d, exp);
    endtask

    task automatic countHigh(input int n, output int cnt);
        cnt = 0;
        repeat (n) begin
            @(posedge clk);
            #1 cnt += (loadOn === 1'b1);
        end
    endtask

    task automatic waitLine();
        int i;
        i = 0;
        do begin
            @(posedge clk);
            #1 i++;
        end while (lineCycle !== 1'b1 && i < 4 * LINE);
        if (i >= 4 * LINE) begin
            bad_count++;
            results();
        end
    endtask

    task automatic waitRise();
        int   i;
        logic prev;
        i = 0;
        prev = 1'b1;
        while (!(prev === 1'b0 && driveOut === 1'b1)) begin
            prev = driveOut;
            @(posedge clk);
            #1 i++;
            if (i > 5000) begin
                bad_count++;
                results();
            end
        end
    endtask

    // one sample per line cycle; level runs must be whole blocks of three
    task automatic lineSample(input int n, output int ons, output logic badRun);
        int   run;
        logic prev;
        logic first;
        ons = 0;
        run = 0;
        first = 1'b1;
        badRun = 1'b0;
        for (int k = 0; k < n; k++) begin
            waitLine();
            if (k > 0 && driveOut !== prev) begin
                if (!first && run % 3 != 0) badRun = 1'b1;
                first = 1'b0;
                run = 0;
            end
            run++;
            prev = driveOut;
            ons += (driveOut === 1'b1);
        end
    endtask

    task automatic sense(input logic c, input logic v, input logic exp);
        @(posedge clk);
        closeReq <= c;
        voltReq  <= v;
        cycles(3);
        #1 checkVal({30'h0, driveEn_n, digitalResult}, {30'h0, 1'b1, exp});
    endtask

    task automatic testReset();
        #1 checkVal({29'h0, digitalResult, driveEn_n, driveOut}, 32'h2);
        regCheck(OFF_CTRL, 32'h0);
        regCheck(OFF_PERIOD, 32'hA);
        regCheck(OFF_LOW, 32'h0);
        regCheck(OFF_HIGH, 32'h3E8);
        regCheck(8'h18, 32'h0);
        @(posedge clk);
        #1 checkVal(rdata, 32'h0);
    endtask

    task automatic testInputs();
        regWrite(OFF_CTRL, 32'h0);
        sense(1'b1, 1'b0, 1'b1);
        sense(1'b0, 1'b1, 1'b0);
        regWrite(OFF_CTRL, 32'h2);
        sense(1'b0, 1'b1, 1'b1);
        sense(1'b1, 1'b0, 1'b0);
        regWrite(OFF_CTRL, 32'h3);
        regCheck(OFF_CTRL, 32'h2);
    endtask

    task automatic testDigitalOut();
        int cnt;
        regWrite(OFF_CTRL, 32'h1);
        regWrite(OFF_CMD, 32'h0001_01F4);
        cycles(3);
        #1 checkVal({30'h0, driveEn_n, driveOut}, 32'h1);
        countHigh(300, cnt);
        checkVal(cnt, 32'h12C);
        regWrite(OFF_CMD, 32'h0000_03E8);
        cycles(3);
        countHigh(300, cnt);
        checkVal(cnt, 32'h0);
    endtask

    task automatic testScaling();
        logic [9:0]  lo [6] = '{10'h0C8, 10'h0C8, 10'h0C8, 10'h0C8, 10'h384, 10'h000};
        logic [9:0]  hi [6] = '{10'h320, 10'h320, 10'h320, 10'h320, 10'h064, 10'h3E8};
        logic [15:0] cm [6] = '{16'h000, 16'h0FA, 16'h3E8, 16'h7D0, 16'h0FA, 16'h1F4};
        logic [9:0]  ex [6] = '{10'h0C8, 10'h15E, 10'h320, 10'h320, 10'h2BC, 10'h1F4};
        logic [31:0] st;
        regWrite(OFF_CTRL, 32'h9);
        foreach (cm[i]) begin
            regWrite(OFF_LOW, {22'h0, lo[i]});
            regWrite(OFF_HIGH, {22'h0, hi[i]});
            regWrite(OFF_CMD, {16'h0, cm[i]});
            cycles(2);
            regRead(OFF_STATUS, st);
            checkVal({22'h0, st[STAT_EFF_LSB+PCT_W-1:STAT_EFF_LSB]}, {22'h0, ex[i]});
        end
    endtask

    task automatic testFixed();
        int          cnt;
        logic [15:0] cm [4] = '{16'h0000, 16'h03E8, 16'h02EE, 16'h000A};
        logic [31:0] ex [4] = '{32'h0, 32'h7D0, 32'h5DC, 32'h14};
        regWrite(OFF_CTRL, 32'h9);
        regWrite(OFF_LOW, 32'h0);
        regWrite(OFF_HIGH, 32'h3E8);
        regWrite(OFF_PERIOD, 32'h0);
        regCheck(OFF_PERIOD, 32'h1);
        regWrite(OFF_PERIOD, 32'h3FF);
        regCheck(OFF_PERIOD, 32'h258);
        regWrite(OFF_PERIOD, 32'h1);
        foreach (cm[i]) begin
            regWrite(OFF_CMD, {16'h0, cm[i]});
            cycles(2100);
            countHigh(2000, cnt);
            checkVal(cnt, ex[i]);
        end
        regWrite(OFF_LOW, 32'h12C);
        regWrite(OFF_CMD, 32'h0);
        cycles(2100);
        countHigh(2000, cnt);
        checkVal(cnt, 32'h258);
        regWrite(OFF_LOW, 32'h0);
        regWrite(OFF_PERIOD, 32'h2);
        regWrite(OFF_CMD, 32'h2EE);
        cycles(4100);
        countHigh(4000, cnt);
        checkVal(cnt, 32'hBB8);
        waitRise();
        cycles(100);
        regWrite(OFF_CMD, 32'h0FA);
        cycles(1000);
        #1 checkVal({31'h0, driveOut}, 32'h1);
        cycles(1500);
        #1 checkVal({31'h0, driveOut}, 32'h0);
    endtask

    task automatic testVariable();
        int          ons;
        logic        badRun;
        logic [15:0] cm [5] = '{16'h0000, 16'h00FA, 16'h01F4, 16'h02EE, 16'h03E8};
        logic [31:0] ex [5] = '{32'h0, 32'h3, 32'h6, 32'h9, 32'hC};
        regWrite(OFF_CTRL, 32'hD);
        foreach (cm[i]) begin
            regWrite(OFF_CMD, {16'h0, cm[i]});
            lineSample(6, ons, badRun);
            lineSample(12, ons, badRun);
            checkVal(ons, ex[i]);
            checkVal({31'h0, badRun}, 32'h0);
        end
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        testReset();
        testInputs();
        testDigitalOut();
        testScaling();
        testFixed();
        testVariable();
        results();
    end
endmodule
`default_nettype wire
